// *** rtl/smart_card_timer2.v ***
// second 8-bit card-link down counter with mode control and avalon slave
//
// Functional notes
// - A 4-bit mode selector sits in bits 27:24 of timer2_control, 31:28 reserved.
// - Mode 0000 starts counting as soon as the run enable bit is set.
// - Each timeout lasts the programmed count plus one time unit.
// - Mode 0000 at zero sets the irq flag and clears the run enable.
// - Mode 0001 waits after enable for the first start bit in either direction.
// - Mode 0001 at zero sets the irq flag and clears the run enable.
// - Mode 0010 starts on the first received start bit, then ends like 0001.
// - Mode 0100 starts on enable, at zero flags, reloads and keeps counting.
// - The 8-bit reload count sits in bits 7:0 of timer2_control.
// - With update-anytime set, reload mode takes a new count at each zero.
`timescale 1ns/10ps
`include "timer2_map.vh"
module smart_card_timer2 #(
    parameter DIV_W = 12
) (
    input wire clk_i,
    input wire nrst_i,
    input wire [7:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output reg [31:0] avs_readdata_o,
    output reg avs_waitrequest_o,
    input wire rx_start_i,
    input wire tx_start_i,
    output reg timeout_o,
    output reg running_o
);

    // ==========================================================
    // state codes, one-hot
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_ARMED = 3'b010;
    localparam [2:0] ST_COUNT = 3'b100;

    // reset words, sliced per field so no bits are dropped silently
    localparam [31:0] CTRL_RST = `TMR2_CTRL_RST;
    localparam [2:0] ALT_RST = `ALT_CTRL_RST;

    reg [3:0] op_mode_r;
    reg [7:0] reload_count_r;
    reg second_timer_run_enable_r;
    reg second_timer_irq_flag_r;
    reg second_timer_update_anytime_r;
    reg [DIV_W-1:0] etu_div_r;
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [7:0] down_cnt_r;
    reg [7:0] down_cnt_nxt;
    reg [7:0] latched_count_r;
    reg [7:0] latched_count_nxt;
    reg hw_clear_en;
    reg hw_set_flag;
    reg load_now;
    reg [31:0] rd_mux;

    wire etu_tick;
    wire bus_req;
    wire bus_take;
    wire wr_take;
    wire wr_alt;
    wire wr_ctrl;
    wire wr_div;
    wire start_seen;
    wire mode_known;
    wire mode_waits;
    wire en_rise;

    // ==========================================================
    // avalon handshake
    // one wait cycle per access, so read data comes from a flop
    assign bus_req = avs_read_i | avs_write_i;
    assign bus_take = bus_req & ~avs_waitrequest_o;
    assign wr_take = avs_write_i & ~avs_waitrequest_o;
    assign wr_alt = wr_take & (avs_address_i == `ALT_CTRL_OFS);
    assign wr_ctrl = wr_take & (avs_address_i == `TMR2_CTRL_OFS);
    assign wr_div = wr_take & (avs_address_i == `ETU_DIV_OFS);

    // waitrequest drops for exactly one cycle per request
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            avs_waitrequest_o <= 1'b1;
        end
        else if (bus_req & avs_waitrequest_o)
        begin
            avs_waitrequest_o <= 1'b0;
        end
        else
        begin
            avs_waitrequest_o <= 1'b1;
        end
    end

    // read mux; unmapped offsets read as zero
    always @*
    begin
        rd_mux = 32'h00000000;
        case (avs_address_i)
            `ALT_CTRL_OFS:
            begin
                rd_mux[`RUN_EN_BIT] = second_timer_run_enable_r;
                rd_mux[`IRQ_FLAG_BIT] = second_timer_irq_flag_r;
                rd_mux[`UPD_ANY_BIT] = second_timer_update_anytime_r;
            end
            `TMR2_CTRL_OFS:
            begin
                rd_mux[`MODE_MSB:`MODE_LSB] = op_mode_r;
                rd_mux[`COUNT_MSB:`COUNT_LSB] = reload_count_r;
            end
            `TMR2_STAT_OFS:
            begin
                rd_mux[7:0] = down_cnt_r;
                rd_mux[`STAT_ARMED_BIT] = state_r[1];
                rd_mux[`STAT_COUNT_BIT] = state_r[2];
            end
            `ETU_DIV_OFS:
            begin
                rd_mux[DIV_W-1:0] = etu_div_r;
            end
            default:
            begin
                rd_mux = 32'h00000000;
            end
        endcase
    end

    // read data captured in the wait cycle, stands at the taking edge
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            avs_readdata_o <= 32'h00000000;
        end
        else if (avs_read_i & avs_waitrequest_o)
        begin
            avs_readdata_o <= rd_mux;
        end
    end

    // ==========================================================
    // software registers
    // mode and count fields, byte-lane gated
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            op_mode_r <= CTRL_RST[`MODE_MSB:`MODE_LSB];
            reload_count_r <= CTRL_RST[`COUNT_MSB:`COUNT_LSB];
        end
        else if (wr_ctrl)
        begin
            if (avs_byteenable_i[3])
            begin
                op_mode_r <= avs_writedata_i[`MODE_MSB:`MODE_LSB];
            end
            if (avs_byteenable_i[0])
            begin
                reload_count_r <= avs_writedata_i[`COUNT_MSB:`COUNT_LSB];
            end
        end
    end

    // alternate control: hardware clear of enable loses to a software write
    // so a restart written at expiry is not swallowed
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            second_timer_run_enable_r <= ALT_RST[`RUN_EN_BIT];
            second_timer_update_anytime_r <= ALT_RST[`UPD_ANY_BIT];
        end
        else if (wr_alt & avs_byteenable_i[0])
        begin
            second_timer_run_enable_r <= avs_writedata_i[`RUN_EN_BIT];
            second_timer_update_anytime_r <= avs_writedata_i[`UPD_ANY_BIT];
        end
        else if (hw_clear_en)
        begin
            second_timer_run_enable_r <= 1'b0;
        end
    end

    // irq flag: write one to clear, a set in the same cycle wins
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            second_timer_irq_flag_r <= ALT_RST[`IRQ_FLAG_BIT];
        end
        else if (hw_set_flag)
        begin
            second_timer_irq_flag_r <= 1'b1;
        end
        else if (wr_alt & avs_byteenable_i[0] &
                 avs_writedata_i[`IRQ_FLAG_BIT])
        begin
            second_timer_irq_flag_r <= 1'b0;
        end
    end

    // time unit divisor, low two byte lanes
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            etu_div_r <= `ETU_DIV_RST;
        end
        else if (wr_div)
        begin
            if (avs_byteenable_i[0])
            begin
                etu_div_r[7:0] <= avs_writedata_i[7:0];
            end
            if (avs_byteenable_i[1])
            begin
                etu_div_r[DIV_W-1:8] <= avs_writedata_i[DIV_W-1:8];
            end
        end
    end

    // ==========================================================
    // time unit tick, realigned whenever the counter starts, not at a reload
    etu_tick_gen #(
        .DIV_W(DIV_W)
    ) u_tick (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .restart_i(load_now),
        .divisor_i(etu_div_r),
        .tick_o(etu_tick)
    );

    // ==========================================================
    // mode decode
    // unlisted modes never start, the counter just stays idle
    assign mode_known = (op_mode_r == `MODE_ON_ENABLE) |
                        (op_mode_r == `MODE_ANY_START) |
                        (op_mode_r == `MODE_RX_START) |
                        (op_mode_r == `MODE_RELOAD);
    assign mode_waits = (op_mode_r == `MODE_ANY_START) |
                        (op_mode_r == `MODE_RX_START);
    // rx-only mode ignores transmit start bits
    assign start_seen = (op_mode_r == `MODE_RX_START) ? rx_start_i :
                        (rx_start_i | tx_start_i);
    assign en_rise = second_timer_run_enable_r & (state_r == ST_IDLE);

    // ==========================================================
    // counter sequencer
    always @*
    begin
        state_nxt = state_r;
        down_cnt_nxt = down_cnt_r;
        latched_count_nxt = latched_count_r;
        hw_clear_en = 1'b0;
        hw_set_flag = 1'b0;
        load_now = 1'b0;
        // update-anytime lets a new count reach the next reload
        if (second_timer_update_anytime_r)
        begin
            latched_count_nxt = reload_count_r;
        end
        case (state_r)
            ST_IDLE:
            begin
                if (en_rise & mode_known)
                begin
                    latched_count_nxt = reload_count_r;
                    if (mode_waits)
                    begin
                        state_nxt = ST_ARMED;
                    end
                    else
                    begin
                        state_nxt = ST_COUNT;
                        down_cnt_nxt = reload_count_r;
                        load_now = 1'b1;
                    end
                end
            end
            ST_ARMED:
            begin
                if (!second_timer_run_enable_r)
                begin
                    state_nxt = ST_IDLE;
                end
                else if (start_seen)
                begin
                    state_nxt = ST_COUNT;
                    down_cnt_nxt = latched_count_r;
                    load_now = 1'b1;
                end
            end
            ST_COUNT:
            begin
                if (!second_timer_run_enable_r)
                begin
                    state_nxt = ST_IDLE;
                end
                else if (etu_tick)
                begin
                    // zero is held one unit, giving count plus one units
                    if (down_cnt_r == 8'h00)
                    begin
                        hw_set_flag = 1'b1;
                        if (op_mode_r == `MODE_RELOAD)
                        begin
                            down_cnt_nxt = latched_count_nxt;
                        end
                        else
                        begin
                            hw_clear_en = 1'b1;
                            state_nxt = ST_IDLE;
                        end
                    end
                    else
                    begin
                        down_cnt_nxt = down_cnt_r - 8'h01;
                    end
                end
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // sequencer flops and registered outputs
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_r <= ST_IDLE;
            down_cnt_r <= 8'h00;
            latched_count_r <= 8'h00;
            timeout_o <= 1'b0;
            running_o <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            down_cnt_r <= down_cnt_nxt;
            latched_count_r <= latched_count_nxt;
            timeout_o <= hw_set_flag;
            running_o <= (state_nxt == ST_COUNT);
        end
    end

endmodule

// *** rtl/timer2_map.vh ***
// register map, field positions and reset values of the second card timer
`ifndef TIMER2_MAP_VH
`define TIMER2_MAP_VH

// byte offsets on the register bus
`define ALT_CTRL_OFS 8'h08
`define TMR2_CTRL_OFS 8'h30
`define TMR2_STAT_OFS 8'h34
`define ETU_DIV_OFS 8'h38

// timer2_control fields
`define MODE_MSB 27
`define MODE_LSB 24
`define COUNT_MSB 7
`define COUNT_LSB 0

// alternate_control_register fields
`define RUN_EN_BIT 0
`define IRQ_FLAG_BIT 1
`define UPD_ANY_BIT 2

// status register fields
`define STAT_ARMED_BIT 8
`define STAT_COUNT_BIT 9

// operation mode encodings
`define MODE_ON_ENABLE 4'h0
`define MODE_ANY_START 4'h1
`define MODE_RX_START 4'h2
`define MODE_RELOAD 4'h4

// reset values
`define TMR2_CTRL_RST 32'h00000000
`define ALT_CTRL_RST 3'h0
`define ETU_DIV_RST 12'h010

`endif

// *** rtl/etu_tick_gen.v ***
// elementary time unit divider producing a one-cycle tick enable
`timescale 1ns/10ps
module etu_tick_gen #(
    parameter DIV_W = 12
) (
    input wire clk_i,
    input wire nrst_i,
    input wire restart_i,
    input wire [DIV_W-1:0] divisor_i,
    output reg tick_o
);

    reg [DIV_W-1:0] div_cnt_r;

    // ==========================================================
    // divider: one tick every divisor_i+1 clocks
    // restart aligns the first unit to a full length
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            div_cnt_r <= {DIV_W{1'b0}};
            tick_o <= 1'b0;
        end
        else if (restart_i)
        begin
            div_cnt_r <= divisor_i;
            tick_o <= 1'b0;
        end
        else if (div_cnt_r == {DIV_W{1'b0}})
        begin
            div_cnt_r <= divisor_i;
            tick_o <= 1'b1;
        end
        else
        begin
            div_cnt_r <= div_cnt_r - {{(DIV_W-1){1'b0}}, 1'b1};
            tick_o <= 1'b0;
        end
    end

endmodule

// *** sim/card_model.sv ***
// behavioural card that sends character start bits on request
`timescale 1ns/10ps
module card_model (
    input wire clk_i,
    input wire nrst_i,
    input wire rx_req_i,
    input wire tx_req_i,
    input wire [7:0] delay_i,
    output reg rx_start_o,
    output reg tx_start_o
);
    // ==========================================
    // start bit generator
    reg [7:0] wait_r;
    reg dir_r;
    // delay_i sets how slowly the card answers; pulses last one cycle
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            wait_r <= 8'h00;
            dir_r <= 1'b0;
            rx_start_o <= 1'b0;
            tx_start_o <= 1'b0;
        end
        else
        begin
            rx_start_o <= 1'b0;
            tx_start_o <= 1'b0;
            if (rx_req_i | tx_req_i)
            begin
                wait_r <= delay_i + 8'h01;
                dir_r <= rx_req_i;
            end
            else if (wait_r != 8'h00)
            begin
                wait_r <= wait_r - 8'h01;
                rx_start_o <= (wait_r == 8'h01) & dir_r;
                tx_start_o <= (wait_r == 8'h01) & ~dir_r;
            end
        end
    end
endmodule

// *** sim/timer2_props.sv ***
// port checker for the second card timer
`timescale 1ns/10ps
module timer2_props (
    input wire clk_i,
    input wire nrst_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_readdata_o,
    input wire avs_waitrequest_o,
    input wire rx_start_i,
    input wire tx_start_i,
    input wire timeout_o,
    input wire running_o
);
    // ==========================================
    // bus and timer properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    wire req = avs_read_i | avs_write_i;
    a_wait_answer: assert property (
        req && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("late");
    a_wait_once: assert property (
        !avs_waitrequest_o |=> avs_waitrequest_o) else $error("wait long");
    a_wait_idle: assert property (
        !req |=> avs_waitrequest_o) else $error("idle answer");
    a_read_hold: assert property (
        !(avs_read_i && avs_waitrequest_o) |=> $stable(avs_readdata_o))
        else $error("read data moved");
    a_timeout_pulse: assert property (
        timeout_o |=> !timeout_o) else $error("expiry too long");
    a_timeout_cause: assert property (
        timeout_o |-> $past(running_o)) else $error("expiry while idle");
    // a start needs an enable write or a start bit shortly before
    a_start_cause: assert property (
        $rose(running_o) |-> $past(avs_write_i) || $past(rx_start_i)
        || $past(tx_start_i) || $past(avs_write_i, 2)
        || $past(rx_start_i, 2) || $past(tx_start_i, 2))
        else $error("start without cause");
    a_stop_cause: assert property (
        $fell(running_o) |-> timeout_o || $past(timeout_o)
        || $past(avs_write_i) || $past(avs_write_i, 2))
        else $error("stop without cause");
    c_expiry: cover property (timeout_o);
    c_start: cover property ($rose(running_o));
    c_read: cover property (avs_read_i && !avs_waitrequest_o);
endmodule

bind smart_card_timer2 timer2_props u_props (
    .clk_i(clk_i), .nrst_i(nrst_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .rx_start_i(rx_start_i),
    .tx_start_i(tx_start_i), .timeout_o(timeout_o), .running_o(running_o));

// *** sim/tb_top.sv ***
// self-checking bench for the second card timer
`timescale 1ns/10ps
`include "timer2_map.vh"
module tb_top;
    reg clk_i = 1'b0;
    reg nrst_i = 1'b0;
    reg [7:0] adr = 8'h00;
    reg rd_i = 1'b0;
    reg wr_i = 1'b0;
    reg [31:0] wdat = 32'h00000000;
    reg [3:0] ben = 4'hF;
    reg rx_req = 1'b0;
    reg tx_req = 1'b0;
    reg [7:0] delay = 8'h00;
    wire [31:0] rdat;
    wire wreq, rx_s, tx_s, tout, run;
    integer bad_count = 0;
    integer checks_done = 0;
    integer n;
    reg [31:0] rd;
    // ==========================================
    // clock, design and card
    always #50 clk_i = ~clk_i;
    smart_card_timer2 u_dut (.clk_i(clk_i), .nrst_i(nrst_i),
        .avs_address_i(adr), .avs_read_i(rd_i), .avs_write_i(wr_i),
        .avs_writedata_i(wdat), .avs_byteenable_i(ben),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
        .rx_start_i(rx_s), .tx_start_i(tx_s), .timeout_o(tout),
        .running_o(run));
    card_model u_card (.clk_i(clk_i), .nrst_i(nrst_i), .rx_req_i(rx_req),
        .tx_req_i(tx_req), .delay_i(delay), .rx_start_o(rx_s),
        .tx_start_o(tx_s));
    // ==========================================
    // tasks
    task complete_run;
    begin
        if (bad_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
    begin
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            bad_count = bad_count + 1;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    end
    endtask
    // one access; values read after an edge are the pre-edge ones
    task bus(input w, input [7:0] a, input [31:0] d);
    begin
        adr <= a;
        wdat <= d;
        wr_i <= w;
        rd_i <= ~w;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n = n + 1;
        end
        while (wreq !== 1'b0 && n < 100);
        // a slave that never answers counts against the run
        if (wreq !== 1'b0)
            bad_count = bad_count + 1;
        rd = rdat;
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        @(posedge clk_i);
    end
    endtask
    task rchk(input [7:0] a, input [31:0] exp);
    begin
        bus(1'b0, a, 32'h00000000);
        chk(rd, exp);
    end
    endtask
    task card(input is_rx);
    begin
        rx_req <= is_rx;
        tx_req <= ~is_rx;
        @(posedge clk_i);
        rx_req <= 1'b0;
        tx_req <= 1'b0;
    end
    endtask
    // cycles up to the next expiry pulse, bounded
    task wait_to;
    begin
        n = 0;
        do
        begin
            @(posedge clk_i);
            n = n + 1;
        end
        while (tout !== 1'b1 && n < 3000);
        if (tout !== 1'b1)
            bad_count = bad_count + 1;
    end
    endtask
    // ==========================================
    // tests; divisor 3 gives a time unit of four clocks
    initial
    begin
        repeat (16) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        rchk(`TMR2_CTRL_OFS, `TMR2_CTRL_RST);
        rchk(`ALT_CTRL_OFS, 32'h00000000);
        rchk(`ETU_DIV_OFS, 32'h00000010);
        rchk(8'h3C, 32'h00000000);
        bus(1'b1, `TMR2_CTRL_OFS, 32'hFF0000A5);
        rchk(`TMR2_CTRL_OFS, 32'h0F0000A5);
        // top lane only: mode moves, count keeps its value
        ben <= 4'h8;
        bus(1'b1, `TMR2_CTRL_OFS, 32'h030000FF);
        ben <= 4'hF;
        rchk(`TMR2_CTRL_OFS, 32'h030000A5);
        // an unlisted mode never starts, even when enabled
        bus(1'b1, `ALT_CTRL_OFS, 32'h00000001);
        repeat (30) @(posedge clk_i);
        chk(run, 32'h0);
        bus(1'b1, `ALT_CTRL_OFS, 32'h00000000);
        bus(1'b1, `ETU_DIV_OFS, 32'h00000003);
        // mode 0 starts on enable and stops itself
        bus(1'b1, `TMR2_CTRL_OFS, 32'h00000005);
        bus(1'b1, `ALT_CTRL_OFS, 32'h00000001);
        wait_to;
        chk(n >= 21 && n <= 28, 32'h1);
        rchk(`ALT_CTRL_OFS, 32'h00000002);
        bus(1'b1, `ALT_CTRL_OFS, 32'h00000002);
        rchk(`ALT_CTRL_OFS, 32'h00000000);
        // mode 1 waits armed for a transmit start bit
        bus(1'b1, `TMR2_CTRL_OFS, 32'h01000003);
        bus(1'b1, `ALT_CTRL_OFS, 32'h00000001);
        repeat (30) @(posedge clk_i);
        chk(run, 32'h0);
        bus(1'b0, `TMR2_STAT_OFS, 32'h00000000);
        chk(rd & 32'h00000300, 32'h00000100);
        card(1'b0);
        wait_to;
        chk(n >= 16 && n <= 24, 32'h1);
        rchk(`ALT_CTRL_OFS, 32'h00000002);
        bus(1'b1, `ALT_CTRL_OFS, 32'h00000002);
        // mode 2 ignores transmit, a slow receive start bit starts it
        bus(1'b1, `TMR2_CTRL_OFS, 32'h02000003);
        bus(1'b1, `ALT_CTRL_OFS, 32'h00000001);
        card(1'b0);
        repeat (20) @(posedge clk_i);
        chk(run, 32'h0);
        delay <= 8'h05;
        card(1'b1);
        wait_to;
        chk(n >= 21 && n <= 30, 32'h1);
        rchk(`ALT_CTRL_OFS, 32'h00000002);
        bus(1'b1, `ALT_CTRL_OFS, 32'h00000002);
        // mode 4 reloads and runs on until enable is cleared
        bus(1'b1, `TMR2_CTRL_OFS, 32'h04000002);
        bus(1'b1, `ALT_CTRL_OFS, 32'h00000001);
        wait_to;
        wait_to;
        chk(n, 32'd12);
        chk(run, 32'h1);
        rchk(`ALT_CTRL_OFS, 32'h00000003);
        // with update-anytime the new count applies from the next zero
        bus(1'b1, `ALT_CTRL_OFS, 32'h00000005);
        bus(1'b1, `TMR2_CTRL_OFS, 32'h04000005);
        wait_to;
        wait_to;
        chk(n, 32'd24);
        // update-anytime off: a new count must not reach the reload
        bus(1'b1, `ALT_CTRL_OFS, 32'h00000001);
        bus(1'b1, `TMR2_CTRL_OFS, 32'h04000002);
        wait_to;
        wait_to;
        chk(n, 32'd24);
        bus(1'b1, `ALT_CTRL_OFS, 32'h00000000);
        repeat (60) @(posedge clk_i);
        chk(run, 32'h0);
        complete_run;
    end
    // watchdog: the tests need well under 2000 cycles
    initial
    begin
        repeat (20000) @(posedge clk_i);
        bad_count = bad_count + 1;
        complete_run;
    end
endmodule
